// ===== rtl/isp_slave_port.sv
// Two-wire slave port giving a bus master access to the configuration registers.
`include "isp_defines.svh"

// Notes on behaviour
// (R01) STOP ends frame anywhere, except START's pulse.
// (R02) Master never sends STOP in START's pulse.
// (R03) Hold SDA low through ninth pulse after writes.
// (R04) Master may retry after a missing acknowledge.
// (R05) Master acknowledges reads, NACK and STOP last.
// (R06) Write frame: address, pointer, data bytes, STOP.
// (R07) Second write byte loads the pointer, acknowledged.
// (R08) Data bytes stored at pointer and acknowledged.
// (R09) Pointer advances after each stored byte.
// (R10) Write pointer saturates at the top register.
// (R11) Read address acknowledged, then data transmitted.
// (R12) Read right after START begins at register zero.
// (R13) Transmitted bit valid at SCL rising edge.
// (R14) Pointer advances after each transmitted byte.
// (R15) STOP accepted after any read byte, bus released.
// (R16) Pointer write, repeated START, read keeps pointer.
// (R17) Read pointer stops at the top register.
// (R18) Two strap inputs choose one of four addresses.
// (R19) Hold input low enables the serial port.
// (R20) SDA open drain: pull low or release.
// (R21) START and STOP are SDA edges with SCL high.
// (R22) SDA changes only while SCL low.
// (R23) Bytes are eight bits, MSB first, plus acknowledge.
// (R24) Repeated START starts new address phase.
// (R25) Fixed upper address bits, others ignored.
// (R26) Both lines pass two-stage synchronisers.
module isp_slave_port
   import isp_pkg::*;
#(
   parameter int FIFO_DEPTH = `ISP_FIFO_DEPTH
) (
   input  wire logic       clock,
   input  wire logic       rst,
   input  wire logic       sclIn,
   input  wire logic       sdaIn,
   output logic            sdaOut,
   output logic            sdaOe,
   input  wire logic       addrSelectLow,
   input  wire logic       addrSelectHigh,
   input  wire logic       procHoldN,
   input  wire logic       cfgStall,
   input  wire logic [3:0] cfgRdAddr,
   output logic      [7:0] cfgRdData,
   output logic            frameActive
);
   initial begin
      if (FIFO_DEPTH < 2) $error("isp_slave_port: FIFO_DEPTH too small");
   end

   // ----------------------------------------------------------------
   // Pin synchronisers and bus condition detection
   // ----------------------------------------------------------------
   logic [1:0] sclSync_ff;
   logic [1:0] sdaSync_ff;
   logic [1:0] selLowSync_ff;
   logic [1:0] selHighSync_ff;
   logic [1:0] holdSync_ff;
   logic       sclDly_ff;
   logic       sdaDly_ff;
   logic       startHigh_ff;

   always_ff @(posedge clock) begin
      if (rst) begin
         sclSync_ff     <= 2'h3;
         sdaSync_ff     <= 2'h3;
         selLowSync_ff  <= 2'h0;
         selHighSync_ff <= 2'h0;
         holdSync_ff    <= 2'h3;
         sclDly_ff      <= 1'b1;
         sdaDly_ff      <= 1'b1;
      end else begin
         sclSync_ff     <= {sclSync_ff[0], sclIn};          // [R26]
         sdaSync_ff     <= {sdaSync_ff[0], sdaIn};          // [R26]
         selLowSync_ff  <= {selLowSync_ff[0], addrSelectLow};
         selHighSync_ff <= {selHighSync_ff[0], addrSelectHigh};
         holdSync_ff    <= {holdSync_ff[0], procHoldN};
         sclDly_ff      <= sclSync_ff[1];
         sdaDly_ff      <= sdaSync_ff[1];
      end
   end

   wire sclNow   = sclSync_ff[1];
   wire sdaNow   = sdaSync_ff[1];
   wire sclRise  = sclNow && !sclDly_ff;
   wire sclFall  = !sclNow && sclDly_ff;
   wire portEn   = !holdSync_ff[1];                                  // [R19]
   wire startDet = portEn && sclNow && sclDly_ff && sdaDly_ff && !sdaNow;  // [R21]
   wire stopRaw  = sclNow && sclDly_ff && !sdaDly_ff && sdaNow;          // [R21]
   // A STOP inside the same high pulse as a START is not honoured.
   wire stopDet  = stopRaw && !startHigh_ff;                             // [R01]

   always_ff @(posedge clock) begin
      if (rst) startHigh_ff <= 1'b0;
      else if (startDet) startHigh_ff <= 1'b1;
      else if (sclFall) startHigh_ff <= 1'b0;
   end

   // ----------------------------------------------------------------
   // Byte engine state
   // ----------------------------------------------------------------
   isp_state_t state_ff;
   isp_state_t nxt_state;
   logic [3:0] bitCnt_ff;
   logic [3:0] nxt_bitCnt;
   logic [7:0] shift_ff;
   logic [7:0] nxt_shift;
   logic [1:0] phase_ff;
   logic [1:0] nxt_phase;
   logic [3:0] ptr_ff;
   logic [3:0] nxt_ptr;
   logic       ptrSet_ff;
   logic       nxt_ptrSet;
   logic       goRead_ff;
   logic       nxt_goRead;
   logic       mAck_ff;
   logic       nxt_mAck;
   logic       sdaOe_ff;
   logic       nxt_sdaOe;
   logic       push;
   logic [7:0] memRdData;
   logic       fifoInReady;
   logic       fifoOutValid;
   logic [11:0] fifoOutData;

   wire [6:0] ownAddr   = {`ISP_ADDR_FIXED, selHighSync_ff[1], selLowSync_ff[1]};  // [R18] [R25]
   wire       byteDone  = (state_ff == ST_RECV) && sclFall && (bitCnt_ff == `ISP_BYTE_BITS);
   wire       addrHit   = shift_ff[7:1] == ownAddr;                  // [R25]
   wire       readDir   = shift_ff[0];
   wire       sendDone  = (state_ff == ST_SEND) && sclFall && (bitCnt_ff == `ISP_BYTE_BITS);
   wire       ptrAtTop  = ptr_ff == `ISP_TOP_REG;
   wire [3:0] ptrInc    = ptrAtTop ? `ISP_TOP_REG : ptr_ff + 4'h1;   // [R10] [R17]
   wire       ptrOver   = shift_ff > {4'h0, `ISP_TOP_REG};
   wire [3:0] ptrLoad   = ptrOver ? `ISP_TOP_REG : shift_ff[3:0];

   always_comb begin
      nxt_state  = state_ff;
      nxt_bitCnt = bitCnt_ff;
      nxt_shift  = shift_ff;
      nxt_phase  = phase_ff;
      nxt_ptr    = ptr_ff;
      nxt_ptrSet = ptrSet_ff;
      nxt_goRead = goRead_ff;
      nxt_mAck   = mAck_ff;
      nxt_sdaOe  = sdaOe_ff;
      push       = 1'b0;
      if (stopDet) begin                                     // [R01] [R15]
         nxt_state  = ST_IDLE;
         nxt_sdaOe  = 1'b0;
         nxt_ptrSet = 1'b0;
      end else if (startDet) begin                           // [R24]
         nxt_state  = ST_RECV;
         nxt_bitCnt = 4'h0;
         nxt_phase  = `ISP_PH_ADDR;
         nxt_goRead = 1'b0;
         nxt_sdaOe  = 1'b0;
      end else begin
         unique case (state_ff)
            ST_IDLE: begin
               nxt_sdaOe = 1'b0;
            end
            ST_RECV: begin
               if (sclRise) begin                           // [R23]
                  nxt_shift  = {shift_ff[6:0], sdaNow};
                  nxt_bitCnt = bitCnt_ff + 4'h1;
               end else if (byteDone) begin
                  nxt_state = ST_ACK;
                  nxt_sdaOe = 1'b1;                          // [R03]
                  if (phase_ff == `ISP_PH_ADDR) begin
                     if (!addrHit) begin                    // [R25]
                        nxt_state = ST_IDLE;
                        nxt_sdaOe = 1'b0;
                     end else if (readDir) begin            // [R11]
                        nxt_goRead = 1'b1;
                        if (!ptrSet_ff) nxt_ptr = 4'h0;     // [R12]
                        nxt_ptrSet = 1'b0;                  // [R16]
                     end else begin
                        nxt_phase = `ISP_PH_PTR;
                     end
                  end else if (phase_ff == `ISP_PH_PTR) begin
                     nxt_ptr    = ptrLoad;                   // [R07]
                     nxt_ptrSet = 1'b1;
                     nxt_phase  = `ISP_PH_DATA;
                  end else if (fifoInReady) begin
                     push    = 1'b1;                         // [R08]
                     nxt_ptr = ptrInc;                       // [R09] [R10]
                  end else begin
                     // Busy: no acknowledge, the master may retry.
                     nxt_state = ST_IDLE;                    // [R04]
                     nxt_sdaOe = 1'b0;
                  end
               end
            end
            ST_ACK: begin
               if (sclFall) begin
                  nxt_bitCnt = 4'h0;
                  if (goRead_ff) begin
                     nxt_state = ST_SEND;
                     nxt_shift = memRdData;
                     nxt_sdaOe = !memRdData[7];              // [R13] [R20]
                  end else begin
                     nxt_state = ST_RECV;
                     nxt_sdaOe = 1'b0;
                  end
               end
            end
            ST_SEND: begin
               if (sclRise) begin
                  nxt_bitCnt = bitCnt_ff + 4'h1;
               end else if (sendDone) begin
                  nxt_state = ST_RACK;
                  nxt_sdaOe = 1'b0;
                  nxt_ptr   = ptrInc;                        // [R14] [R17]
               end else if (sclFall) begin
                  nxt_shift = {shift_ff[6:0], 1'b0};
                  nxt_sdaOe = !shift_ff[6];                  // [R13] [R22]
               end
            end
            ST_RACK: begin
               if (sclRise) begin
                  nxt_mAck = !sdaNow;                        // [R05]
               end else if (sclFall) begin
                  nxt_bitCnt = 4'h0;
                  if (mAck_ff) begin
                     nxt_state = ST_SEND;
                     nxt_shift = memRdData;
                     nxt_sdaOe = !memRdData[7];              // [R13]
                  end else begin
                     nxt_state = ST_IDLE;
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         state_ff  <= ST_IDLE;
         bitCnt_ff <= 4'h0;
         shift_ff  <= 8'h00;
         phase_ff  <= `ISP_PH_ADDR;
         ptr_ff    <= 4'h0;
         ptrSet_ff <= 1'b0;
         goRead_ff <= 1'b0;
         mAck_ff   <= 1'b0;
         sdaOe_ff  <= 1'b0;
      end else begin
         state_ff  <= nxt_state;
         bitCnt_ff <= nxt_bitCnt;
         shift_ff  <= nxt_shift;
         phase_ff  <= nxt_phase;
         ptr_ff    <= nxt_ptr;
         ptrSet_ff <= nxt_ptrSet;
         goRead_ff <= nxt_goRead;
         mAck_ff   <= nxt_mAck;
         sdaOe_ff  <= nxt_sdaOe;
      end
   end

   logic frameActive_ff;
   always_ff @(posedge clock) begin
      if (rst) frameActive_ff <= 1'b0;
      else frameActive_ff <= nxt_state != ST_IDLE;
   end

   // The pin is only ever pulled low or released.
   assign sdaOut      = 1'b0;                                // [R20]
   assign sdaOe       = sdaOe_ff;
   assign frameActive = frameActive_ff;

   // ----------------------------------------------------------------
   // Write buffer and register storage
   // ----------------------------------------------------------------
   isp_fifo #(.WIDTH(12), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clock    (clock),
      .rst      (rst),
      .inValid  (push),
      .inReady  (fifoInReady),
      .inData   ({ptr_ff, shift_ff}),
      .outValid (fifoOutValid),
      .outReady (!cfgStall),
      .outData  (fifoOutData)
   );

   isp_reg_mem #(.AW(4), .DW(8), .DEPTH(`ISP_REG_COUNT)) u_mem (
      .clock   (clock),
      .rst     (rst),
      .wrEn    (fifoOutValid && !cfgStall),
      .wrAddr  (fifoOutData[11:8]),
      .wrData  (fifoOutData[7:0]),
      .rdAddrA (ptr_ff),
      .rdDataA (memRdData),
      .rdAddrB (cfgRdAddr),
      .rdDataB (cfgRdData)
   );

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   chk_stop_ends_frame: assert property (@(posedge clock) disable iff (rst) // [R01]
      stopDet |=> state_ff == ST_IDLE && !sdaOe_ff)
      else $error("STOP did not end the frame");
   chk_write_ack_hold: assert property (@(posedge clock) disable iff (rst) // [R03]
      (byteDone && phase_ff == `ISP_PH_DATA && fifoInReady && !stopDet && !startDet)
      |=> sdaOe_ff && state_ff == ST_ACK)
      else $error("Write acknowledge not raised");
   chk_ack_held: assert property (@(posedge clock) disable iff (rst) // [R03]
      (state_ff == ST_ACK && !sclFall && !stopDet && !startDet)
      |=> sdaOe_ff && state_ff == ST_ACK)
      else $error("Acknowledge released before the ninth pulse ended");
   chk_ptr_load_value: assert property (@(posedge clock) disable iff (rst) // [R07]
      (byteDone && phase_ff == `ISP_PH_PTR && !stopDet && !startDet) |=> ptr_ff == $past(ptrLoad))
      else $error("Pointer byte not loaded");
   chk_ptr_write_incr: assert property (@(posedge clock) disable iff (rst) // [R09]
      push |=> ptr_ff == (($past(ptr_ff) == `ISP_TOP_REG) ? `ISP_TOP_REG : $past(ptr_ff) + 4'h1))
      else $error("Pointer did not advance after write");
   chk_read_from_zero: assert property (@(posedge clock) disable iff (rst) // [R12]
      (byteDone && phase_ff == `ISP_PH_ADDR && addrHit && readDir && !ptrSet_ff
       && !stopDet && !startDet) |=> ptr_ff == 4'h0 && goRead_ff)
      else $error("Plain read did not start at register zero");
   chk_read_keeps_ptr: assert property (@(posedge clock) disable iff (rst) // [R16]
      (byteDone && phase_ff == `ISP_PH_ADDR && addrHit && readDir && ptrSet_ff
       && !stopDet && !startDet) |=> ptr_ff == $past(ptr_ff))
      else $error("Indexed read lost the pointer");
   chk_sda_stable_high: assert property (@(posedge clock) disable iff (rst) // [R13]
      (state_ff == ST_SEND && sclRise && !stopDet && !startDet) |=> $stable(sdaOe_ff))
      else $error("Transmit bit changed at SCL rise");
   chk_read_ptr_top: assert property (@(posedge clock) disable iff (rst) // [R17]
      (sendDone && ptrAtTop && !stopDet && !startDet) |=> ptr_ff == `ISP_TOP_REG)
      else $error("Read pointer passed top register");
   chk_foreign_addr: assert property (@(posedge clock) disable iff (rst) // [R25]
      (byteDone && phase_ff == `ISP_PH_ADDR && !addrHit && !stopDet && !startDet)
      |=> state_ff == ST_IDLE && !sdaOe_ff)
      else $error("Foreign address was answered");
   cov_write_data: cover property (@(posedge clock) disable iff (rst) push);
   cov_read_byte: cover property (@(posedge clock) disable iff (rst) sendDone);
   cov_stop_in_read: cover property (@(posedge clock) disable iff (rst)
      stopDet && state_ff == ST_RACK);
endmodule // isp_slave_port

// ===== rtl/isp_defines.svh
// Constants of the two-wire register slave port.
`ifndef ISP_DEFINES_SVH
`define ISP_DEFINES_SVH
`define ISP_ADDR_FIXED  5'h14
`define ISP_TOP_REG     4'hB
`define ISP_REG_COUNT   12
`define ISP_BYTE_BITS   4'h8
`define ISP_PH_ADDR     2'h0
`define ISP_PH_PTR      2'h1
`define ISP_PH_DATA     2'h2
`define ISP_FIFO_DEPTH  8
`endif

// ===== rtl/isp_pkg.sv
// Types shared by the two-wire register slave port.
package isp_pkg;
   typedef enum logic [4:0] {
      ST_IDLE = 5'b00001,
      ST_RECV = 5'b00010,
      ST_ACK  = 5'b00100,
      ST_SEND = 5'b01000,
      ST_RACK = 5'b10000
   } isp_state_t;
endpackage

// ===== rtl/isp_fifo.sv
// Small synchronous FIFO with valid and ready on both sides.
module isp_fifo #(
   parameter int WIDTH = 12,
   parameter int DEPTH = 8
) (
   input  wire logic             clock,
   input  wire logic             rst,
   input  wire logic             inValid,
   output logic                  inReady,
   input  wire logic [WIDTH-1:0] inData,
   output logic                  outValid,
   input  wire logic             outReady,
   output logic      [WIDTH-1:0] outData
);
   localparam int AW = $clog2(DEPTH);
   initial begin
      if (DEPTH < 2 || (1 << AW) != DEPTH) $error("isp_fifo: DEPTH must be a power of two");
   end
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wrPtr_ff;
   logic [AW:0]      rdPtr_ff;
   wire              doPush = inValid && inReady;
   wire              doPop  = outValid && outReady;
   assign inReady  = (wrPtr_ff - rdPtr_ff) != (AW+1)'(DEPTH);
   assign outValid = wrPtr_ff != rdPtr_ff;
   assign outData  = mem[rdPtr_ff[AW-1:0]];
   always_ff @(posedge clock) begin
      if (rst) begin
         wrPtr_ff <= '0;
         rdPtr_ff <= '0;
      end else begin
         if (doPush) wrPtr_ff <= wrPtr_ff + 1'b1;
         if (doPop) rdPtr_ff <= rdPtr_ff + 1'b1;
      end
   end
   always_ff @(posedge clock) begin
      if (doPush) mem[wrPtr_ff[AW-1:0]] <= inData;
   end
endmodule // isp_fifo

// ===== rtl/isp_reg_mem.sv
// Register storage: one write port, two registered read ports.
module isp_reg_mem #(
   parameter int AW    = 4,
   parameter int DW    = 8,
   parameter int DEPTH = 12
) (
   input  wire logic          clock,
   input  wire logic          rst,
   input  wire logic          wrEn,
   input  wire logic [AW-1:0] wrAddr,
   input  wire logic [DW-1:0] wrData,
   input  wire logic [AW-1:0] rdAddrA,
   output logic      [DW-1:0] rdDataA,
   input  wire logic [AW-1:0] rdAddrB,
   output logic      [DW-1:0] rdDataB
);
   initial begin
      if (DEPTH > (1 << AW)) $error("isp_reg_mem: DEPTH exceeds address range");
   end
   logic [DW-1:0] regs [DEPTH];
   always_ff @(posedge clock) begin
      if (rst) begin
         for (int i = 0; i < DEPTH; i++) regs[i] <= '0;
      end else if (wrEn && int'(wrAddr) < DEPTH) begin
         regs[wrAddr] <= wrData;
      end
   end
   always_ff @(posedge clock) begin
      if (rst) begin
         rdDataA <= '0;
         rdDataB <= '0;
      end else begin
         rdDataA <= (int'(rdAddrA) < DEPTH) ? regs[rdAddrA] : '0;
         rdDataB <= (int'(rdAddrB) < DEPTH) ? regs[rdAddrB] : '0;
      end
   end
endmodule // isp_reg_mem

// ===== test/isp_master_model.sv
// Bus master model that clocks the two-wire port and drives its data line open drain.
module isp_master_model (
   input  wire logic clock,
   input  wire logic sda,
   output logic      scl,
   output logic      sdaLow
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      scl = 1'b1;
      sdaLow = 1'b0;
   end

   task automatic hold(input int n);
      repeat (n) @(negedge clock);
   endtask

   // ------------------------------------------------------------------
   // Bus conditions
   // ------------------------------------------------------------------
   // Start or repeated start: SDA falls while SCL is high.
   task automatic startCond();
      hold(2);
      sdaLow = 1'b0;
      hold(3);
      scl = 1'b1;
      hold(3);
      sdaLow = 1'b1;
      hold(3);
      scl = 1'b0;
   endtask

   // Stop comes only after a full low phase, never in the high pulse of a start.
   task automatic stopCond();
      hold(2);
      sdaLow = 1'b1;
      hold(3);
      scl = 1'b1;
      hold(3);
      sdaLow = 1'b0;
      hold(8);
   endtask

   // ------------------------------------------------------------------
   // Bits and bytes
   // ------------------------------------------------------------------
   // SDA moves only while SCL is low; a level that moves in the high pulse reads as unknown.
   task automatic bitXfer(input logic b, output logic r);
      logic r0;
      hold(2);
      sdaLow = !b;
      hold(3);
      scl = 1'b1;
      hold(1);
      r0 = sda;
      hold(2);
      r = (sda === r0) ? r0 : 1'bx;
      scl = 1'b0;
   endtask

   // Eight bits MSB first, then the acknowledge bit.
   task automatic byteXfer(input logic [7:0] d, input logic ackIn, output logic [7:0] q,
                           output logic ackOut);
      logic b;
      for (int i = 7; i >= 0; i--) begin
         bitXfer(d[i], b);
         q[i] = b;
      end
      bitXfer(ackIn, ackOut);
   endtask
endmodule // isp_master_model

// ===== test/tb_top.sv
// Self-checking bench of the two-wire register slave port.
`include "isp_defines.svh"
`define CHK(got, exp) begin \
   checked++; \
   if ((got) !== (exp)) begin \
      mismatches++; \
      $display("BAD %0t got %0h expected %0h", $time, (got), (exp)); \
   end \
end

module tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   typedef struct packed {
      logic [1:0] strap;
      logic [1:0] sent;
      logic [7:0] ptr;
      logic [7:0] data;
   } isp_row_t;

   logic       clock;
   logic       rst;
   logic       scl;
   logic       mstLow;
   logic       strapLo;
   logic       strapHi;
   logic       procHoldN;
   logic       cfgStall;
   logic [3:0] cfgRdAddr;
   logic [7:0] cfgRdData;
   logic       sdaOut;
   logic       sdaOe;
   logic       frameActive;
   wire logic  sdaWire;
   int         mismatches;
   int         checked;
   logic [7:0] shd [12];
   isp_row_t   rows [6] = '{'{2'h0, 2'h0, 8'h01, 8'hA5}, '{2'h1, 2'h1, 8'h03, 8'h5A},
                            '{2'h2, 2'h2, 8'h07, 8'hC3}, '{2'h3, 2'h3, 8'h0B, 8'h3C},
                            '{2'h2, 2'h1, 8'h04, 8'h77}, '{2'h0, 2'h3, 8'h05, 8'h88}};

   // Wired-AND of both open-drain drivers with the pull-up.
   assign sdaWire = !(mstLow || (sdaOe && !sdaOut));

   isp_slave_port #(.FIFO_DEPTH(`ISP_FIFO_DEPTH)) dut (
      .clock(clock), .rst(rst), .sclIn(scl), .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe),
      .addrSelectLow(strapLo), .addrSelectHigh(strapHi), .procHoldN(procHoldN),
      .cfgStall(cfgStall), .cfgRdAddr(cfgRdAddr), .cfgRdData(cfgRdData),
      .frameActive(frameActive));

   isp_master_model mst (.clock(clock), .sda(sdaWire), .scl(scl), .sdaLow(mstLow));

   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   // ------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------
   task automatic print_verdict();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chkRegs();
      for (int i = 0; i < 12; i++) begin
         @(negedge clock);
         cfgRdAddr = 4'(i);
         repeat (2) @(negedge clock);
         `CHK(cfgRdData, shd[i])
      end
   endtask

   task automatic addrPh(input logic [1:0] sel, input logic rw, output logic a);
      logic [7:0] q;
      mst.startCond();
      mst.byteXfer({`ISP_ADDR_FIXED, sel, rw}, 1'b1, q, a);
   endtask

   task automatic wrFrame(input logic [7:0] ptr, input int n, input logic [7:0] base,
                          input int nAck);
      logic [7:0] q;
      logic       a;
      logic [3:0] p;
      p = (ptr > 8'h0B) ? `ISP_TOP_REG : ptr[3:0];
      addrPh({strapHi, strapLo}, 1'b0, a);
      `CHK(a, 1'b0)
      mst.byteXfer(ptr, 1'b1, q, a);
      `CHK(a, 1'b0)
      for (int i = 0; i < n; i++) begin
         mst.byteXfer(base + 8'(i), 1'b1, q, a);
         `CHK(a, (i >= nAck))
         if (i < nAck) shd[p] = base + 8'(i);
         if (i < nAck && p < `ISP_TOP_REG) p++;
      end
      mst.stopCond();
   endtask

   // The last byte is followed by a not-acknowledge and a stop.
   task automatic rdFrame(input logic preset, input logic [7:0] ptr, input int n);
      logic [7:0] q;
      logic       a;
      logic [3:0] p;
      p = 4'h0;
      if (preset) begin
         addrPh({strapHi, strapLo}, 1'b0, a);
         mst.byteXfer(ptr, 1'b1, q, a);
         `CHK(a, 1'b0)
         p = (ptr > 8'h0B) ? `ISP_TOP_REG : ptr[3:0];
      end
      addrPh({strapHi, strapLo}, 1'b1, a);
      `CHK(a, 1'b0)
      for (int i = 0; i < n; i++) begin
         mst.byteXfer(8'hFF, (i == n - 1), q, a);
         `CHK(q, shd[p])
         if (p < `ISP_TOP_REG) p++;
      end
      mst.stopCond();
      `CHK(frameActive, 1'b0)
   endtask

   // ------------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------------
   initial begin
      logic a;
      logic b;
      rst = 1'b1;
      strapLo = 1'b0;
      strapHi = 1'b0;
      procHoldN = 1'b0;
      cfgStall = 1'b0;
      cfgRdAddr = 4'h0;
      mismatches = 0;
      checked = 0;
      foreach (shd[i]) shd[i] = 8'h00;
      repeat (6) @(negedge clock);
      rst = 1'b0;
      repeat (3) @(negedge clock);
      `CHK(sdaOe, 1'b0)
      `CHK(sdaOut, 1'b0)
      `CHK(frameActive, 1'b0)
      chkRegs();
      foreach (rows[k]) begin
         {strapHi, strapLo} = rows[k].strap;
         if (rows[k].sent == rows[k].strap) wrFrame(rows[k].ptr, 1, rows[k].data, 1);
         else begin
            addrPh(rows[k].sent, 1'b0, a);
            `CHK(a, 1'b1)
            mst.stopCond();
         end
      end
      chkRegs();
      wrFrame(8'h0A, 3, 8'h61, 3);
      wrFrame(8'h3F, 2, 8'h90, 2);
      chkRegs();
      rdFrame(1'b0, 8'h00, 13);
      rdFrame(1'b1, 8'h05, 2);
      rdFrame(1'b0, 8'h00, 1);
      rdFrame(1'b1, 8'h20, 2);
      addrPh({strapHi, strapLo}, 1'b0, a);
      repeat (3) mst.bitXfer(1'b0, b);
      mst.stopCond();
      `CHK(frameActive, 1'b0)
      wrFrame(8'h02, 1, 8'h4E, 1);
      procHoldN = 1'b1;
      addrPh({strapHi, strapLo}, 1'b0, a);
      `CHK(a, 1'b1)
      mst.stopCond();
      procHoldN = 1'b0;
      cfgStall = 1'b1;
      wrFrame(8'h00, 9, 8'hD0, 8);
      cfgStall = 1'b0;
      wrFrame(8'h08, 1, 8'hD8, 1);
      chkRegs();
      // A reset in the middle of a frame drops the frame and clears the registers.
      addrPh({strapHi, strapLo}, 1'b0, a);
      `CHK(frameActive, 1'b1)
      rst = 1'b1;
      repeat (6) @(negedge clock);
      `CHK(sdaOe, 1'b0)
      `CHK(frameActive, 1'b0)
      rst = 1'b0;
      repeat (3) @(negedge clock);
      mst.stopCond();
      foreach (shd[i]) shd[i] = 8'h00;
      chkRegs();
      wrFrame(8'h04, 1, 8'h2D, 1);
      rdFrame(1'b1, 8'h04, 1);
      print_verdict();
   end

   initial begin
      repeat (50000) @(posedge clock);
      mismatches++;
      $display("BAD %0t run too long", $time);
      print_verdict();
   end
endmodule // tb_top
